// *** core/idc_decode.sv ***
/*
 Instruction decode and cycle timing control.
 Assumes program memory returns the addressed word in the same cycle and
 that condition results are supplied by the execute logic with the word.
*/
`include "idc_params.svh"

// Notes on behaviour
// - Each single word is 24 bits; an 8-bit opcode selects type.
// - Almost all instructions take one word; exactly three take two.
// - Two-word instructions use 48 bits; second word top byte is zero.
// - A lone second word executes as a no-operation.
// - Most single-word instructions finish in one cycle.
// - A true branch condition, branch or indirect jump adds one no-operation cycle.
// - Branch, indirect jump, table access and returns take two or three cycles.
// - Skip costs two cycles over one word, three over two words.
// - Two-word instructions take exactly two cycles.
// - Working register ops yield base, second source and destination.
// - File ops yield file address and file or working register zero.
// - Bit ops yield target and bit from literal or register.
// - Literal moves yield literal and target register.
// - Literal ALU ops use base and literal; destination only if different.
// - Control ops yield program address or table mode.
module idc_decode
    import idc_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_b_in,
    // Program memory
    input wire logic [23:0] prog_word_in,
    input wire logic prog_valid_in,
    // Execute feedback
    input wire logic cond_true_in,
    input wire logic next_is_two_word_in,
    // Decoded instruction
    output logic instr_valid_out,
    output logic [7:0] opcode_out,
    output idc_pkg::idc_fmt_t fmt_out,
    output logic [3:0] base_source_reg_out,
    output logic [3:0] second_source_reg_out,
    output logic [3:0] dest_reg_out,
    output logic [2:0] src_mode_out,
    output logic [12:0] file_addr_out,
    output logic to_working_reg_zero_out,
    output logic [3:0] bit_pos_out,
    output logic [15:0] literal_out,
    output logic dest_separate_out,
    output logic [22:0] prog_addr_out,
    output logic [2:0] table_mode_out,
    // Timing
    output logic [1:0] cycles_out,
    output logic no_operation_out,
    output logic fetch_second_out,
    output logic busy_out
);
    import idc_pkg::*;

    // ----------------------------------------------------------------
    // Field extraction and cycle classification
    // ----------------------------------------------------------------
    idc_fmt_t f_fmt;
    logic [3:0] f_bsrc, f_ssrc, f_dst, f_bit;
    logic [2:0] f_mode;
    logic [12:0] f_file;
    logic f_wz, f_sep, c_two;
    logic [15:0] f_lit;
    logic [1:0] c_cycles;
    logic [7:0] opc;

    assign opc = prog_word_in[`IDC_OPC_MSB:`IDC_OPC_LSB];

    idc_fields u_fields (
        .word_in(prog_word_in),
        .fmt_out(f_fmt),
        .base_source_reg_out(f_bsrc),
        .second_source_reg_out(f_ssrc),
        .dest_reg_out(f_dst),
        .src_mode_out(f_mode),
        .file_addr_out(f_file),
        .to_working_reg_zero_out(f_wz),
        .bit_pos_out(f_bit),
        .literal_out(f_lit),
        .dest_separate_out(f_sep)
    );

    idc_cycles u_cycles (
        .opc_in(opc),
        .cond_true_in(cond_true_in),
        .next_is_two_word_in(next_is_two_word_in),
        .two_word_out(c_two),
        .cycles_out(c_cycles)
    );

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    idc_state_t state_reg, state_next;
    logic [1:0] fill_reg, fill_next;
    logic [7:0] opc_reg, opc_next;
    logic [1:0] cyc_reg, cyc_next;
    logic valid_reg, valid_next;
    logic no_op_reg, no_op_next;
    logic fetch2_reg, fetch2_next;
    logic [22:0] addr_reg, addr_next;
    logic [2:0] tmode_reg, tmode_next;
    logic [15:0] first_low_reg, first_low_next;
    idc_fmt_t fmt_reg, fmt_next;
    logic [3:0] bsrc_reg, bsrc_next, ssrc_reg, ssrc_next, dst_reg, dst_next, bit_reg, bit_next;
    logic [2:0] mode_reg, mode_next;
    logic [12:0] file_reg, file_next;
    logic wz_reg, wz_next, sep_reg, sep_next;
    logic [15:0] lit_reg, lit_next;
    // Busy is registered so the memory side reads a level with no decode logic behind it.
    logic busy_reg, busy_next;

    always_comb begin
        state_next = state_reg;
        fill_next = fill_reg;
        opc_next = opc_reg;
        cyc_next = cyc_reg;
        valid_next = 1'b0;
        no_op_next = 1'b0;
        fetch2_next = 1'b0;
        addr_next = addr_reg;
        tmode_next = tmode_reg;
        first_low_next = first_low_reg;
        fmt_next = fmt_reg;
        bsrc_next = bsrc_reg;
        ssrc_next = ssrc_reg;
        dst_next = dst_reg;
        bit_next = bit_reg;
        mode_next = mode_reg;
        file_next = file_reg;
        wz_next = wz_reg;
        sep_next = sep_reg;
        lit_next = lit_reg;
        case (state_reg)
            IDC_ST_FIRST: begin
                if (prog_valid_in) begin
                    opc_next = opc;
                    cyc_next = c_cycles;
                    fmt_next = f_fmt;
                    bsrc_next = f_bsrc;
                    ssrc_next = f_ssrc;
                    dst_next = f_dst;
                    bit_next = f_bit;
                    mode_next = f_mode;
                    file_next = f_file;
                    wz_next = f_wz;
                    sep_next = f_sep;
                    lit_next = f_lit;
                    tmode_next = prog_word_in[`IDC_MODE_S_LSB +: `IDC_MODE_W];
                    addr_next = {7'h00, prog_word_in[15:0]};
                    if (opc == `IDC_OPC_NO_OP) begin
                        // A lone second word has a zero top byte and so lands here.
                        no_op_next = 1'b1;
                        valid_next = 1'b1;
                        fmt_next = IDC_FMT_NONE;
                    end else if (c_two) begin
                        first_low_next = prog_word_in[15:0];
                        fetch2_next = 1'b1;
                        state_next = IDC_ST_SECOND;
                    end else begin
                        valid_next = 1'b1;
                        if (c_cycles > 2'h1) begin
                            fill_next = c_cycles - 2'h1;
                            state_next = IDC_ST_FILL;
                        end
                    end
                end
            end
            IDC_ST_SECOND: begin
                if (prog_valid_in) begin
                    // The second word's top byte is expected zero; its low 7 bits above the first word's low 16 form the 23-bit address.
                    addr_next = {prog_word_in[6:0], first_low_reg};
                    lit_next = first_low_reg;
                    valid_next = 1'b1;
                    fill_next = 2'h0;
                    state_next = IDC_ST_FIRST;
                end
            end
            IDC_ST_FILL: begin
                no_op_next = 1'b1;
                fill_next = fill_reg - 2'h1;
                if (fill_reg == 2'h1) begin
                    state_next = IDC_ST_FIRST;
                end
            end
            default: state_next = IDC_ST_FIRST;
        endcase
        busy_next = (state_next != IDC_ST_FIRST);
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_reg <= IDC_ST_FIRST;
            fill_reg <= 2'h0;
            opc_reg <= 8'h00;
            cyc_reg <= 2'h0;
            valid_reg <= 1'b0;
            no_op_reg <= 1'b0;
            fetch2_reg <= 1'b0;
            addr_reg <= 23'h000000;
            tmode_reg <= 3'h0;
            first_low_reg <= 16'h0000;
            fmt_reg <= IDC_FMT_NONE;
            bsrc_reg <= 4'h0;
            ssrc_reg <= 4'h0;
            dst_reg <= 4'h0;
            bit_reg <= 4'h0;
            mode_reg <= 3'h0;
            file_reg <= 13'h0000;
            wz_reg <= 1'b0;
            sep_reg <= 1'b0;
            lit_reg <= 16'h0000;
            busy_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            fill_reg <= fill_next;
            opc_reg <= opc_next;
            cyc_reg <= cyc_next;
            valid_reg <= valid_next;
            no_op_reg <= no_op_next;
            fetch2_reg <= fetch2_next;
            addr_reg <= addr_next;
            tmode_reg <= tmode_next;
            first_low_reg <= first_low_next;
            fmt_reg <= fmt_next;
            bsrc_reg <= bsrc_next;
            ssrc_reg <= ssrc_next;
            dst_reg <= dst_next;
            bit_reg <= bit_next;
            mode_reg <= mode_next;
            file_reg <= file_next;
            wz_reg <= wz_next;
            sep_reg <= sep_next;
            lit_reg <= lit_next;
            busy_reg <= busy_next;
        end
    end

    assign instr_valid_out = valid_reg;
    assign opcode_out = opc_reg;
    assign fmt_out = fmt_reg;
    assign base_source_reg_out = bsrc_reg;
    assign second_source_reg_out = ssrc_reg;
    assign dest_reg_out = dst_reg;
    assign src_mode_out = mode_reg;
    assign file_addr_out = file_reg;
    assign to_working_reg_zero_out = wz_reg;
    assign bit_pos_out = bit_reg;
    assign literal_out = lit_reg;
    assign dest_separate_out = sep_reg;
    assign prog_addr_out = addr_reg;
    assign table_mode_out = tmode_reg;
    assign cycles_out = cyc_reg;
    assign no_operation_out = no_op_reg;
    assign fetch_second_out = fetch2_reg;
    assign busy_out = busy_reg;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_two_word_second: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (state_reg == IDC_ST_FIRST && prog_valid_in && c_two) |=> (state_reg == IDC_ST_SECOND && fetch2_reg))
        else $error("second word not fetched after first");
    a_two_word_len: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (state_reg == IDC_ST_SECOND && prog_valid_in) |=> (instr_valid_out && cycles_out == 2'h2))
        else $error("two-word instruction not two cycles");
    a_lone_second_word: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (state_reg == IDC_ST_FIRST && prog_valid_in && opc == 8'h00) |=> (no_operation_out && fmt_out == IDC_FMT_NONE))
        else $error("zero opcode not executed as no-operation");
    a_single_cycle: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (state_reg == IDC_ST_FIRST && prog_valid_in && !c_two && c_cycles == 2'h1) |=> (state_reg == IDC_ST_FIRST))
        else $error("single cycle instruction stalled");
    a_fill_two: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (state_reg == IDC_ST_FIRST && prog_valid_in && !c_two && opc != 8'h00 && c_cycles == 2'h2)
        |=> ##1 (no_operation_out && state_reg == IDC_ST_FIRST))
        else $error("two cycle instruction fill wrong");
    a_fill_three: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (state_reg == IDC_ST_FIRST && prog_valid_in && !c_two && opc != 8'h00 && c_cycles == 2'h3)
        |=> ##1 no_operation_out [*2] ##0 (state_reg == IDC_ST_FIRST))
        else $error("three cycle instruction fill wrong");
    a_skip_over_two: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (state_reg == IDC_ST_FIRST && opc == 8'hAF && cond_true_in && next_is_two_word_in) |-> c_cycles == 2'h3)
        else $error("skip over two words not three cycles");
    a_lit_dest: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (instr_valid_out && fmt_out == IDC_FMT_LITALU && dest_separate_out) |-> dest_reg_out != base_source_reg_out)
        else $error("literal destination flagged but equal to base");
endmodule // idc_decode

// *** core/idc_params.svh ***
/*
 Constants for the instruction decode and cycle timing block.
 Assumes inclusion by bare name from files under core/.
*/
`ifndef IDC_PARAMS_SVH
`define IDC_PARAMS_SVH

// ----------------------------------------------------------------
// Word layout
// ----------------------------------------------------------------
`define IDC_WORD_W 24
`define IDC_OPC_MSB 23
`define IDC_OPC_LSB 16
`define IDC_OPC_W 8
`define IDC_REG_W 4
`define IDC_FILE_W 13
`define IDC_LIT_W 16
`define IDC_ADDR_W 23
`define IDC_BIT_W 4
`define IDC_MODE_W 3
`define IDC_CYC_W 2

// ----------------------------------------------------------------
// Field positions inside the low 16 bits
// ----------------------------------------------------------------
`define IDC_DST_LSB 7
`define IDC_BSRC_LSB 11
`define IDC_SSRC_LSB 0
`define IDC_MODE_S_LSB 4
`define IDC_BITPOS_LSB 12
`define IDC_FDEST_BIT 13

// ----------------------------------------------------------------
// Opcode map (upper four bits select the class)
// ----------------------------------------------------------------
`define IDC_OPC_NO_OP 8'h00
`define IDC_OPC_CALL2 8'h02
`define IDC_OPC_GOTO2 8'h04
`define IDC_OPC_DO2 8'h08
`define IDC_OPC_BRANCH 8'h37
`define IDC_OPC_RETURN 8'h06
`define IDC_OPC_RETINT 8'h07
`define IDC_OPC_INDJMP 8'h01
`define IDC_CLS_CTRL 4'h0
`define IDC_CLS_CBRA 4'h3
`define IDC_CLS_WRK 4'h4
`define IDC_CLS_LITALU 4'h5
`define IDC_CLS_MOVLIT 4'h2
`define IDC_CLS_BIT 4'hA
`define IDC_CLS_TBL 4'hB
`define IDC_CLS_FILE 4'hE
`define IDC_OPC_SKIP 8'hAF

`endif

// *** core/idc_pkg.sv ***
/*
 Types shared by the decode block.
 Assumes idc_params.svh is compiled alongside.
*/
package idc_pkg;
    typedef enum logic [2:0] {
        IDC_FMT_NONE,
        IDC_FMT_WRK,
        IDC_FMT_FILE,
        IDC_FMT_BIT,
        IDC_FMT_MOVLIT,
        IDC_FMT_LITALU,
        IDC_FMT_CTRL
    } idc_fmt_t;

    typedef enum logic [1:0] {
        IDC_ST_FIRST,
        IDC_ST_SECOND,
        IDC_ST_FILL
    } idc_state_t;
endpackage

// *** core/idc_fields.sv ***
/*
 Combinational operand field extractor for one 24-bit instruction word.
 Assumes the caller registers every output it drives out.
*/
`include "idc_params.svh"

module idc_fields
    import idc_pkg::*;
(
    // Word
    input wire logic [23:0] word_in,
    // Fields
    output idc_pkg::idc_fmt_t fmt_out,
    output logic [3:0] base_source_reg_out,
    output logic [3:0] second_source_reg_out,
    output logic [3:0] dest_reg_out,
    output logic [2:0] src_mode_out,
    output logic [12:0] file_addr_out,
    output logic to_working_reg_zero_out,
    output logic [3:0] bit_pos_out,
    output logic [15:0] literal_out,
    output logic dest_separate_out
);
    logic [7:0] opc;
    logic [3:0] cls;

    assign opc = word_in[`IDC_OPC_MSB:`IDC_OPC_LSB];
    assign cls = opc[7:4];
    assign base_source_reg_out = word_in[`IDC_BSRC_LSB +: `IDC_REG_W];
    assign second_source_reg_out = word_in[`IDC_SSRC_LSB +: `IDC_REG_W];
    assign dest_reg_out = word_in[`IDC_DST_LSB +: `IDC_REG_W];
    assign src_mode_out = word_in[`IDC_MODE_S_LSB +: `IDC_MODE_W];
    assign file_addr_out = word_in[`IDC_FILE_W-1:0];
    assign to_working_reg_zero_out = ~word_in[`IDC_FDEST_BIT];
    assign literal_out = word_in[`IDC_LIT_W-1:0];
    // The bit position comes from a literal or, for the register form, from the base register.
    assign bit_pos_out = opc[0] ? word_in[`IDC_BSRC_LSB +: `IDC_REG_W] : word_in[`IDC_BITPOS_LSB +: `IDC_BIT_W];
    // A literal ALU op names a destination only when it differs from the base source.
    assign dest_separate_out = (cls == `IDC_CLS_LITALU) &&
                               (word_in[`IDC_DST_LSB +: `IDC_REG_W] != word_in[`IDC_BSRC_LSB +: `IDC_REG_W]);

    always_comb begin
        case (cls)
            `IDC_CLS_WRK: fmt_out = IDC_FMT_WRK;
            `IDC_CLS_FILE: fmt_out = IDC_FMT_FILE;
            `IDC_CLS_BIT: fmt_out = IDC_FMT_BIT;
            `IDC_CLS_MOVLIT: fmt_out = IDC_FMT_MOVLIT;
            `IDC_CLS_LITALU: fmt_out = IDC_FMT_LITALU;
            `IDC_CLS_CTRL, `IDC_CLS_CBRA, `IDC_CLS_TBL: fmt_out = IDC_FMT_CTRL;
            default: fmt_out = IDC_FMT_NONE;
        endcase
    end
endmodule // idc_fields

// *** core/idc_cycles.sv ***
/*
 Cycle count classifier for a decoded first word.
 Assumes condition and skip results arrive in the cycle of the word.
*/
`include "idc_params.svh"

module idc_cycles
    import idc_pkg::*;
(
    // Instruction
    input wire logic [7:0] opc_in,
    input wire logic cond_true_in,
    input wire logic next_is_two_word_in,
    // Result
    output logic two_word_out,
    output logic [1:0] cycles_out
);
    function automatic logic is_two_word(input logic [7:0] opc);
        is_two_word = (opc == `IDC_OPC_CALL2) || (opc == `IDC_OPC_GOTO2) || (opc == `IDC_OPC_DO2);
    endfunction

    logic [3:0] cls;
    assign cls = opc_in[7:4];
    assign two_word_out = is_two_word(opc_in);

    always_comb begin
        cycles_out = 2'h1;
        if (is_two_word(opc_in)) begin
            cycles_out = 2'h2;
        end else if (opc_in == `IDC_OPC_SKIP) begin
            if (cond_true_in) begin
                cycles_out = next_is_two_word_in ? 2'h3 : 2'h2;
            end
        end else if (opc_in == `IDC_OPC_RETURN || opc_in == `IDC_OPC_RETINT || cls == `IDC_CLS_TBL) begin
            cycles_out = 2'h3;
        end else if (opc_in == `IDC_OPC_BRANCH || opc_in == `IDC_OPC_INDJMP) begin
            cycles_out = 2'h2;
        end else if (cls == `IDC_CLS_CBRA && cond_true_in) begin
            cycles_out = 2'h2;
        end
    end
endmodule // idc_cycles

// *** tb/idc_prog_mem.sv ***
/*
 Program memory model that hands instruction words to the decode block.
 Assumes the bench loads words with put, in program order, before they are due.
*/
module idc_prog_mem (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_b_in,
    // Decoder status and bench gap select
    input wire logic busy_in,
    input wire logic fetch_second_in,
    input wire logic gap_in,
    // Word path
    output logic [23:0] prog_word_out,
    output logic prog_valid_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [23:0] q[$];
    logic rest_reg;

    task automatic put(input logic [23:0] w);
        q.push_back(w);
    endtask

    // ----------------------------------------------------------------
    // Word presentation
    // ----------------------------------------------------------------
    // Idle cycles show a word that flips every cycle, so a stale word never reads as fresh.
    // A slow memory rests one cycle after each single-word instruction, never inside or after a two-word pair.
    always @(negedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            prog_valid_out <= 1'b0;
            prog_word_out <= 24'hFFFFFF;
            rest_reg <= 1'b0;
        end else if (q.size() != 0 && (fetch_second_in || (!busy_in && !rest_reg))) begin
            prog_word_out <= q.pop_front();
            prog_valid_out <= 1'b1;
            rest_reg <= gap_in && !fetch_second_in;
        end else begin
            prog_word_out <= ~prog_word_out;
            prog_valid_out <= 1'b0;
            rest_reg <= 1'b0;
        end
    end
endmodule // idc_prog_mem

// *** tb/testbench.sv ***
/*
 Self-checking bench for the instruction decode and cycle timing block.
 Assumes idc_pkg, the core files and tb/idc_prog_mem.sv are compiled first.
*/
module testbench;
    import idc_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_in, rst_b_in, prog_valid_in, cond_true_in, next_is_two_word_in, gap;
    logic [23:0] prog_word_in;
    logic instr_valid_out, to_working_reg_zero_out, dest_separate_out;
    logic no_operation_out, fetch_second_out, busy_out;
    logic [7:0] opcode_out;
    idc_fmt_t fmt_out;
    logic [3:0] base_source_reg_out, second_source_reg_out, dest_reg_out, bit_pos_out;
    logic [2:0] src_mode_out, table_mode_out;
    logic [12:0] file_addr_out;
    logic [15:0] literal_out;
    logic [22:0] prog_addr_out;
    logic [1:0] cycles_out;
    int bad_count, samples_checked, cyc_count, n_valid, n_no_op, n_fetch;

    idc_decode uut (.clk_in, .rst_b_in, .prog_word_in, .prog_valid_in, .cond_true_in,
        .next_is_two_word_in, .instr_valid_out, .opcode_out, .fmt_out, .base_source_reg_out,
        .second_source_reg_out, .dest_reg_out, .src_mode_out, .file_addr_out,
        .to_working_reg_zero_out, .bit_pos_out, .literal_out, .dest_separate_out,
        .prog_addr_out, .table_mode_out, .cycles_out, .no_operation_out,
        .fetch_second_out, .busy_out);

    idc_prog_mem pm (.clk_in, .rst_b_in, .busy_in(busy_out), .fetch_second_in(fetch_second_out),
        .gap_in(gap), .prog_word_out(prog_word_in), .prog_valid_out(prog_valid_in));

    initial begin
        clk_in = 1'b0;
        forever #25 clk_in = ~clk_in;
    end

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Runs one instruction and counts the pulses it makes until the core is idle again.
    task automatic run(input logic [23:0] w0, input logic [23:0] w1, input logic two,
                       input logic c, input logic nt);
        @(negedge clk_in);
        cond_true_in = c;
        next_is_two_word_in = nt;
        pm.put(w0);
        if (two) pm.put(w1);
        n_valid = 0;
        n_no_op = 0;
        n_fetch = 0;
        for (int i = 0; i < 12; i++) begin
            @(negedge clk_in);
            n_valid += (instr_valid_out === 1'b1);
            n_no_op += (no_operation_out === 1'b1);
            n_fetch += (fetch_second_out === 1'b1);
            if (n_valid != 0 && busy_out === 1'b0) break;
        end
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_work_reg();
        run(24'h4A5A93, 24'h000000, 1'b0, 1'b0, 1'b0);
        check("valid", n_valid, 32'h1);
        check("cycles", cycles_out, 32'h1);
        check("fill", n_no_op, 32'h0);
        check("opcode", opcode_out, 32'h4A);
        check("fmt", fmt_out, IDC_FMT_WRK);
        check("base", base_source_reg_out, 32'hB);
        check("second", second_source_reg_out, 32'h3);
        check("dest", dest_reg_out, 32'h5);
        check("mode", src_mode_out, 32'h1);
        $display("test work register done");
    endtask

    task automatic t_file_bit();
        logic [15:0] lo;
        logic [7:0] op;
        for (int i = 0; i < 2; i++) begin
            lo = i ? 16'h0ABC : 16'h2ABC;
            run({8'hE5, lo}, 24'h000000, 1'b0, 1'b0, 1'b0);
            check("file fmt", fmt_out, IDC_FMT_FILE);
            check("file addr", file_addr_out, lo[12:0]);
            check("to reg zero", to_working_reg_zero_out, !lo[13]);
            op = i ? 8'hA3 : 8'hA2;
            run({op, 16'h7123}, 24'h000000, 1'b0, 1'b0, 1'b0);
            check("bit fmt", fmt_out, IDC_FMT_BIT);
            check("bit pos", bit_pos_out, i ? 4'hE : 4'h7);
            check("bit target", second_source_reg_out, 32'h3);
        end
        $display("test file and bit done");
    endtask

    task automatic t_literal();
        run(24'h21BEEF, 24'h000000, 1'b0, 1'b0, 1'b0);
        check("move fmt", fmt_out, IDC_FMT_MOVLIT);
        check("move literal", literal_out, 32'hBEEF);
        run(24'h525A93, 24'h000000, 1'b0, 1'b0, 1'b0);
        check("alu fmt", fmt_out, IDC_FMT_LITALU);
        check("alu base", base_source_reg_out, 32'hB);
        check("alu split", dest_separate_out, 32'h1);
        run(24'h522A80, 24'h000000, 1'b0, 1'b0, 1'b0);
        check("alu same", dest_separate_out, 32'h0);
        $display("test literal done");
    endtask

    // Branches, returns, table access and conditional branches with their cycle counts.
    task automatic t_ctrl();
        logic [7:0] ops [7] = '{8'h37, 8'h01, 8'h06, 8'h07, 8'hB4, 8'h32, 8'h32};
        logic cnd [7] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
        logic [1:0] cyc [7] = '{2'h2, 2'h2, 2'h3, 2'h3, 2'h3, 2'h1, 2'h2};
        for (int i = 0; i < 7; i++) begin
            run({ops[i], 16'hC3D5}, 24'h000000, 1'b0, cnd[i], 1'b0);
            check("ctrl cycles", cycles_out, cyc[i]);
            check("ctrl fill", n_no_op, cyc[i] - 2'h1);
            check("ctrl one word", n_fetch, 32'h0);
            if (i == 0) check("branch addr", prog_addr_out, 32'hC3D5);
            if (i == 4) check("table mode", table_mode_out, 32'h5);
        end
        $display("test control done");
    endtask

    task automatic t_skip();
        for (int i = 0; i < 2; i++) begin
            run(24'hAF0001, 24'h000000, 1'b0, 1'b1, i[0]);
            check("skip cycles", cycles_out, i ? 2'h3 : 2'h2);
            check("skip fill", n_no_op, i ? 32'h2 : 32'h1);
        end
        $display("test skip done");
    endtask

    task automatic t_two_word();
        logic [7:0] ops [3] = '{8'h02, 8'h04, 8'h08};
        for (int i = 0; i < 3; i++) begin
            gap = i[0];
            run({ops[i], 16'h1234}, 24'h00005A, 1'b1, 1'b0, 1'b0);
            check("fetch second", n_fetch, 32'h1);
            check("two valid", n_valid, 32'h1);
            check("two cycles", cycles_out, 32'h2);
            check("two opcode", opcode_out, ops[i]);
            check("two addr", prog_addr_out, {7'h5A, 16'h1234});
        end
        gap = 1'b0;
        run(24'h00005A, 24'h000000, 1'b0, 1'b0, 1'b0);
        check("lone no-op", n_no_op, 32'h1);
        check("lone fmt", fmt_out, IDC_FMT_NONE);
        $display("test two word done");
    endtask

    // Three single-cycle words back to back, then again from a slow memory.
    task automatic t_b2b();
        for (int g = 0; g < 2; g++) begin
            @(negedge clk_in);
            gap = g[0];
            n_valid = 0;
            for (int k = 0; k < 3; k++) pm.put(24'h4A0000 | k[23:0]);
            for (int i = 0; i < 8; i++) begin
                @(negedge clk_in);
                n_valid += (instr_valid_out === 1'b1);
                if (i == 3 && g == 0) check("b2b count", n_valid, 32'h3);
            end
            check("b2b total", n_valid, 32'h3);
            check("b2b last", second_source_reg_out, 32'h2);
        end
        gap = 1'b0;
        $display("test back to back done");
    endtask

    // ----------------------------------------------------------------
    // Main sequence and hang guard
    // ----------------------------------------------------------------
    always @(posedge clk_in) begin
        cyc_count++;
        if (cyc_count == 3000) begin
            bad_count++;
            $display("mismatch timeout expected 0 seen %0d", cyc_count);
            give_verdict();
        end
    end

    initial begin
        rst_b_in = 1'b0;
        cond_true_in = 1'b0;
        next_is_two_word_in = 1'b0;
        gap = 1'b0;
        repeat (4) @(posedge clk_in);
        @(negedge clk_in);
        check("reset valid", instr_valid_out, 32'h0);
        check("reset busy", busy_out, 32'h0);
        rst_b_in = 1'b1;
        t_work_reg();
        t_file_bit();
        t_literal();
        t_ctrl();
        t_skip();
        t_two_word();
        t_b2b();
        give_verdict();
    end
endmodule // testbench
